// >>> logic/iraw_top.sv
// Purpose: Indirect register access window: control, offset and data registers
// Assumes: Local register strobes come from the I2C register engine on I_MCLK
// Notes: Target blocks sit on write and read strobes, one bit each, sharing offset and data
`timescale 1ns/1ps
`include "iraw_regs.svh"

module iraw_top #(
  parameter int NUM_TGT = `IRAW_NUM_TGT
) (
  input wire logic I_MCLK,
  input wire logic I_RESETN,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic [NUM_TGT*8-1:0] I_TGT_RDATA,
  output logic [7:0] O_REG_RDATA,
  output logic [NUM_TGT-1:0] O_TGT_WR,
  output logic [NUM_TGT-1:0] O_TGT_RD_STB,
  output logic [7:0] O_TGT_OFFSET,
  output logic [7:0] O_TGT_WDATA
);

  ////////////////////////////////////////////////////////////////////////////
  // Local register decode

  logic [3:0] target_block_select_reg;
  logic offset_auto_increment_reg;
  logic read_strobe_request_reg;
  logic [7:0] target_offset_reg;
  logic strobe_pend_reg;
  iraw_pkg::iraw_mask_t wr_mask;
  iraw_pkg::iraw_mask_t rd_mask;
  logic ctl_wr, off_wr, data_wr, data_rd, data_acc;

  assign ctl_wr = I_REG_WR && (I_REG_ADDR == `IRAW_OFF_CONTROL);
  assign off_wr = I_REG_WR && (I_REG_ADDR == `IRAW_OFF_OFFSET);
  assign data_wr = I_REG_WR && (I_REG_ADDR == `IRAW_OFF_DATA);
  assign data_rd = I_REG_RD && (I_REG_ADDR == `IRAW_OFF_DATA);
  assign data_acc = data_wr || data_rd;

  iraw_sel_decode u_iraw_sel_decode (
    .i_sel(target_block_select_reg),
    .o_wr_mask(wr_mask),
    .o_rd_mask(rd_mask)
  );

  // Picks one target's read byte; empty mask reads zero
  function automatic logic [7:0] pick_byte(input logic [NUM_TGT*8-1:0] bytes, input iraw_pkg::iraw_mask_t m);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < NUM_TGT; k++) begin
      if (m[k]) begin
        r = r | bytes[k*8 +: 8];
      end
    end
    return r;
  endfunction : pick_byte

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  // Select, auto-increment and read request fields; bits 7:6 read zero
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      target_block_select_reg <= 4'(`IRAW_CONTROL_RST >> `IRAW_SEL_LO);
      offset_auto_increment_reg <= 1'b0;
      read_strobe_request_reg <= 1'b0;
    end else if (ctl_wr) begin
      target_block_select_reg <= I_REG_WDATA[`IRAW_SEL_HI:`IRAW_SEL_LO];
      offset_auto_increment_reg <= I_REG_WDATA[`IRAW_AUTO_INC_BIT];
      read_strobe_request_reg <= I_REG_WDATA[`IRAW_READ_REQ_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset register

  // 8-bit offset; a host write wins over an increment in the same cycle
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      target_offset_reg <= `IRAW_OFFSET_RST;
    end else if (off_wr) begin
      target_offset_reg <= I_REG_WDATA;
    end else if (data_acc && offset_auto_increment_reg) begin
      // Advance after the access, wrapping at the top
      target_offset_reg <= target_offset_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read strobe scheduling

  // Strobe waits one cycle so it sees the offset already updated
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      strobe_pend_reg <= 1'b0;
    end else begin
      // Data read refetch in auto-increment mode
      strobe_pend_reg <= read_strobe_request_reg &&
        (off_wr || (data_rd && offset_auto_increment_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target-side outputs

  // Offset follows one cycle behind so write pulses carry the pre-increment value
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      O_TGT_OFFSET <= `IRAW_OFFSET_RST;
      O_TGT_WDATA <= 8'h00;
      O_TGT_WR <= '0;
      O_TGT_RD_STB <= '0;
    end else begin
      O_TGT_OFFSET <= target_offset_reg;
      // Forward data write; reserved codes give an empty mask
      O_TGT_WR <= data_wr ? wr_mask : '0;
      if (data_wr) begin
        O_TGT_WDATA <= I_REG_WDATA;
      end
      O_TGT_RD_STB <= strobe_pend_reg ? rd_mask : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Data read returns the selected block; reserved codes and the dual receive code read zero
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      O_REG_RDATA <= 8'h00;
    end else if (I_REG_RD) begin
      case (I_REG_ADDR)
        `IRAW_OFF_CONTROL: O_REG_RDATA <= {2'b00, target_block_select_reg,
          offset_auto_increment_reg, read_strobe_request_reg};
        `IRAW_OFF_OFFSET: O_REG_RDATA <= target_offset_reg;
        `IRAW_OFF_DATA: O_REG_RDATA <= pick_byte(I_TGT_RDATA, rd_mask);
        default: O_REG_RDATA <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);

  a_write_route_rx0: assert property (
    data_wr && target_block_select_reg == `IRAW_SEL_RX0 |=> O_TGT_WR == 5'h02)
    else $error("RX0 write not routed to port 0 alone");

  a_both_ports_write: assert property (
    data_wr && target_block_select_reg == `IRAW_SEL_BOTH_RX |=> O_TGT_WR == 5'h06)
    else $error("Dual write did not reach both receive ports");

  a_offset_auto_inc: assert property (
    data_acc && !off_wr && offset_auto_increment_reg |=> target_offset_reg == $past(target_offset_reg) + 8'h01)
    else $error("Offset did not advance after data access");

  a_offset_hold: assert property (
    data_acc && !off_wr && !offset_auto_increment_reg |=> $stable(target_offset_reg))
    else $error("Offset moved without auto-increment");

  a_addr_strobe_due: assert property (
    off_wr && read_strobe_request_reg && !ctl_wr && rd_mask != '0 ##1 !ctl_wr |=> O_TGT_RD_STB != '0)
    else $error("No read strobe after offset write");

  a_refetch_strobe: assert property (
    data_rd && read_strobe_request_reg && offset_auto_increment_reg && rd_mask != '0 && !ctl_wr ##1 !ctl_wr
      |=> O_TGT_RD_STB != '0 && O_TGT_OFFSET == $past(target_offset_reg))
    else $error("No refetch strobe at the new offset");

  a_write_offset: assert property (
    data_wr && wr_mask != '0 |=> O_TGT_OFFSET == $past(target_offset_reg) && O_TGT_WDATA == $past(I_REG_WDATA))
    else $error("Target write carries wrong offset or data");

  a_read_csi_data: assert property (
    data_rd && target_block_select_reg == `IRAW_SEL_CSI |=> O_REG_RDATA == $past(I_TGT_RDATA[`IRAW_TGT_CSI*8 +: 8]))
    else $error("Data read did not return CSI-2 byte");

  a_reserved_quiet: assert property (
    data_acc && rd_mask == '0 && wr_mask == '0 |=> O_TGT_WR == '0 ##1 O_TGT_RD_STB == '0)
    else $error("Reserved select touched a target");

  a_reserved_read_zero: assert property (
    data_rd && rd_mask == '0 |=> O_REG_RDATA == 8'h00)
    else $error("Reserved select read not zero");

  // A stray write pulse would silently corrupt a target register
  a_write_pulse_only: assert property (
    !data_wr |=> O_TGT_WR == '0)
    else $error("Target write pulse without a data write");

  // Strobe is two cycles behind the request that caused it
  a_strobe_needs_request: assert property (
    O_TGT_RD_STB != '0 |-> $past(read_strobe_request_reg, 2))
    else $error("Read strobe issued without read request");

  a_offset_load: assert property (
    off_wr |=> target_offset_reg == $past(I_REG_WDATA))
    else $error("Offset write did not load the full byte");

  a_select_load: assert property (
    ctl_wr |=> target_block_select_reg == $past(I_REG_WDATA[`IRAW_SEL_HI:`IRAW_SEL_LO]))
    else $error("Select field not taken from control write");

endmodule : iraw_top

// >>> logic/iraw_regs.svh
// Purpose: Offsets, field positions, codes and reset values of the indirect access window
// Assumes: 8-bit local register space reached by the I2C register engine
// Notes: Definitions only
`ifndef IRAW_REGS_SVH
`define IRAW_REGS_SVH

// Local register offsets
`define IRAW_OFF_CONTROL 8'hB0
`define IRAW_OFF_OFFSET 8'hB1
`define IRAW_OFF_DATA 8'hB2

// Control register fields
`define IRAW_SEL_HI 5
`define IRAW_SEL_LO 2
`define IRAW_AUTO_INC_BIT 1
`define IRAW_READ_REQ_BIT 0

// Reset values
`define IRAW_CONTROL_RST 8'h00
`define IRAW_OFFSET_RST 8'h00

// Target block select codes
`define IRAW_SEL_PATGEN 4'h0
`define IRAW_SEL_RX0 4'h1
`define IRAW_SEL_RX1 4'h2
`define IRAW_SEL_SHARED 4'h5
`define IRAW_SEL_BOTH_RX 4'h6
`define IRAW_SEL_CSI 4'h7

// Target block indices on the strobe vectors, one bit per block
`define IRAW_TGT_PATGEN 0
`define IRAW_TGT_RX0 1
`define IRAW_TGT_RX1 2
`define IRAW_TGT_SHARED 3
`define IRAW_TGT_CSI 4
`define IRAW_NUM_TGT 5

`endif

// >>> logic/iraw_pkg.sv
// Purpose: Shared types of the indirect access window
// Assumes: Constants come from iraw_regs.svh
// Notes: Types only
`include "iraw_regs.svh"

package iraw_pkg;

  // Target select codes
  typedef enum logic [3:0] {
    IRAW_PATGEN = `IRAW_SEL_PATGEN,
    IRAW_RX0 = `IRAW_SEL_RX0,
    IRAW_RX1 = `IRAW_SEL_RX1,
    IRAW_SHARED = `IRAW_SEL_SHARED,
    IRAW_BOTH_RX = `IRAW_SEL_BOTH_RX,
    IRAW_CSI = `IRAW_SEL_CSI
  } iraw_sel_t;

  typedef logic [`IRAW_NUM_TGT-1:0] iraw_mask_t;

endpackage : iraw_pkg

// >>> logic/iraw_sel_decode.sv
// Purpose: Turns the target select code into write and read masks with one bit per target
// Assumes: Pure combinational, same clock domain as the caller
// Notes: Reserved codes give empty masks
`timescale 1ns/1ps
`include "iraw_regs.svh"

module iraw_sel_decode (
  input wire logic [3:0] i_sel,
  output iraw_pkg::iraw_mask_t o_wr_mask,
  output iraw_pkg::iraw_mask_t o_rd_mask
);

  // Write mask: the dual receive code fans out to both ports
  always_comb begin
    o_wr_mask = '0;
    o_rd_mask = '0;
    case (i_sel)
      `IRAW_SEL_PATGEN: o_rd_mask[`IRAW_TGT_PATGEN] = 1'b1;
      `IRAW_SEL_RX0: o_rd_mask[`IRAW_TGT_RX0] = 1'b1;
      `IRAW_SEL_RX1: o_rd_mask[`IRAW_TGT_RX1] = 1'b1;
      `IRAW_SEL_SHARED: o_rd_mask[`IRAW_TGT_SHARED] = 1'b1;
      `IRAW_SEL_CSI: o_rd_mask[`IRAW_TGT_CSI] = 1'b1;
      `IRAW_SEL_BOTH_RX: begin
        // Write-only broadcast, nothing to read back
        o_wr_mask[`IRAW_TGT_RX0] = 1'b1;
        o_wr_mask[`IRAW_TGT_RX1] = 1'b1;
      end
      default: o_rd_mask = '0;
    endcase
    if (i_sel != `IRAW_SEL_BOTH_RX) begin
      o_wr_mask = o_wr_mask | o_rd_mask;
    end
  end

endmodule : iraw_sel_decode

// >>> tb/iraw_tgt_model.sv
// Purpose: Target register blocks behind the indirect window
// Assumes: One write pulse bit per block, shared offset and data
// Notes: Answers live at the shared offset, so no prefetch latch
`timescale 1ns/1ps
module iraw_tgt_model (
  input wire logic i_clk,
  input wire logic [4:0] i_wr,
  input wire logic [7:0] i_off,
  input wire logic [7:0] i_wdata,
  output logic [39:0] o_rdata
);
  logic [7:0] mem [5][256];
  ////////////////////////////////////////////////////////////
  // Seed with a pattern the bench can predict
  initial begin
    for (int t = 0; t < 5; t++) begin
      for (int a = 0; a < 256; a++) mem[t][a] = 8'(a) ^ 8'(t * 8'h11);
    end
  end
  always @(posedge i_clk) begin
    for (int t = 0; t < 5; t++) if (i_wr[t]) mem[t][i_off] <= i_wdata;
  end
  always_comb begin
    for (int t = 0; t < 5; t++) o_rdata[t*8+:8] = mem[t][i_off];
  end
endmodule : iraw_tgt_model

// >>> tb/test_indirect_register_access.sv
// Purpose: Self-checking bench of the indirect access window
// Assumes: Local bus driven just after rising edges
// Notes: Expected results queued, a watcher compares them
`timescale 1ns/1ps
`include "iraw_regs.svh"
`define IRAW_CHK(g, e) check_eq(g, e)
module test_indirect_register_access;
  logic mclk, resetn, wr, rd;
  logic [7:0] addr, wdata, rdata, toff, twdata;
  logic [4:0] twr, tstb;
  logic [39:0] trd;
  logic [7:0] shadow [5][256];
  logic [20:0] rd_q[$], wr_q[$], stb_q[$];
  int miscompares = 0, checks_done = 0;
  logic [31:0] seed = 32'h4C;
  logic rd_d = 1'b0;
  iraw_top u_iraw_top (.I_MCLK(mclk), .I_RESETN(resetn), .I_REG_WR(wr), .I_REG_RD(rd),
    .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_TGT_RDATA(trd), .O_REG_RDATA(rdata),
    .O_TGT_WR(twr), .O_TGT_RD_STB(tstb), .O_TGT_OFFSET(toff), .O_TGT_WDATA(twdata));
  iraw_tgt_model u_iraw_tgt_model (.i_clk(mclk), .i_wr(twr), .i_off(toff), .i_wdata(twdata),
    .o_rdata(trd));
  ////////////////////////////////////////////////////////////
  // Clock at 200 MHz
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic check_eq(input logic [20:0] got, input logic [20:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_eq
  function automatic logic [20:0] pop(ref logic [20:0] q[$]);
    return (q.size() > 0) ? q.pop_front() : 21'h1FFFFF;
  endfunction : pop
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic logic [4:0] msk(input logic [3:0] s);
    case (s)
      4'h0: return 5'h01;
      4'h1: return 5'h02;
      4'h2: return 5'h04;
      4'h5: return 5'h08;
      4'h6: return 5'h06;
      4'h7: return 5'h10;
      default: return 5'h00;
    endcase
  endfunction : msk
  function automatic logic [7:0] rval(input logic [4:0] m, input logic [7:0] o);
    rval = 8'h00;
    for (int t = 0; t < 5; t++) if (m[t]) rval |= shadow[t][o];
  endfunction : rval
  // One single-byte access, then idle cycles so the offset output settles
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input int idle);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (idle) @(posedge mclk);
  endtask : acc
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(21'(e));
    acc(1'b0, a, 8'h00, 2);
  endtask : rdchk
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////
  // Watcher: any result with no note pending is a mismatch
  always @(posedge mclk) begin
    rd_d <= rd;
    // Outputs are unknown until the first reset edge, so watch only out of reset
    if (resetn === 1'b1) begin
      if (rd_d) `IRAW_CHK(21'(rdata), pop(rd_q));
      if (twr !== 5'h00) `IRAW_CHK({twr, toff, twdata}, pop(wr_q));
      if (tstb !== 5'h00) `IRAW_CHK({tstb, toff, 8'h00}, pop(stb_q));
    end
  end
  // Main sequence
  initial begin
    logic [7:0] o, d;
    logic [4:0] m;
    {wr, rd, addr, wdata, resetn} = '0;
    for (int t = 0; t < 5; t++) begin
      for (int a = 0; a < 256; a++) shadow[t][a] = 8'(a) ^ 8'(t * 8'h11);
    end
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    // reset values, read-only bits, unmapped place
    rdchk(`IRAW_OFF_CONTROL, 8'h00);
    rdchk(`IRAW_OFF_OFFSET, 8'h00);
    acc(1'b1, `IRAW_OFF_CONTROL, 8'hFF, 1);
    rdchk(`IRAW_OFF_CONTROL, 8'h3F);
    rdchk(8'hB3, 8'h00);
    $display("test local registers done");
    // every select code, wrap at 0xFF
    for (int s = 0; s < 16; s++) begin
      m = msk(4'(s));
      o = (s == 7) ? 8'hFF : rnd();
      d = rnd();
      acc(1'b1, `IRAW_OFF_CONTROL, {2'b00, 4'(s), 2'b10}, 1);
      acc(1'b1, `IRAW_OFF_OFFSET, o, 1);
      if (m != 5'h00) wr_q.push_back({m, o, d});
      for (int t = 0; t < 5; t++) if (m[t]) shadow[t][o] = d;
      acc(1'b1, `IRAW_OFF_DATA, d, 2);
      if (m != 5'h00) rdchk(`IRAW_OFF_OFFSET, o + 8'h01);
      acc(1'b1, `IRAW_OFF_OFFSET, o, 1);
      rdchk(`IRAW_OFF_DATA, (s == 6) ? 8'h00 : rval(m, o));
      if (m != 5'h00 && s != 6) rdchk(`IRAW_OFF_OFFSET, o + 8'h01);
    end
    $display("test select codes done");
    // read request set only for codes that select a single block
    for (int s = 0; s < 8; s++) begin
      m = msk(4'(s));
      if (!$onehot(m)) continue;
      o = rnd();
      acc(1'b1, `IRAW_OFF_CONTROL, {2'b00, 4'(s), s[0], 1'b1}, 1);
      stb_q.push_back({m, o, 8'h00});
      acc(1'b1, `IRAW_OFF_OFFSET, o, 3);
      rd_q.push_back(21'(rval(m, o)));
      // strobe after a data read only with auto-increment
      if (s[0]) stb_q.push_back({m, o + 8'h01, 8'h00});
      acc(1'b0, `IRAW_OFF_DATA, 8'h00, 3);
    end
    $display("test read strobes done");
    repeat (4) @(posedge mclk);
    `IRAW_CHK(21'(rd_q.size() + wr_q.size() + stb_q.size()), 21'h0);
    close_out();
  end
endmodule : test_indirect_register_access
